//--- rtl/divider_chain_pkg.sv
// shared constants of the fractional-n divider chain
// assumes a 100 MHz system clock and a 32-bit avalon slave
package divider_chain_pkg;
  // clock rate and calibration timing
  localparam int CLK_MHZ = 100;
  localparam int CAL_MID_NS = 1000;
  localparam int CAL_MID_CYC = (CAL_MID_NS * CLK_MHZ + 999) / 1000;
  localparam int CAL_WIN = 16;
  // register byte offsets
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_PATH = 6'h04;
  localparam logic [5:0] REG_RATIO = 6'h08;
  localparam logic [5:0] REG_NINT = 6'h0C;
  localparam logic [5:0] REG_NUM = 6'h10;
  localparam logic [5:0] REG_DEN = 6'h14;
  localparam logic [5:0] REG_SEED = 6'h18;
  localparam logic [5:0] REG_DET = 6'h1C;
  localparam logic [5:0] REG_STAT = 6'h20;
  // field positions
  localparam int CTRL_CAL_BIT = 0;
  localparam int CTRL_ORD_LSB = 1;
  localparam int CTRL_PRE4_BIT = 4;
  localparam int PATH_DBL_BIT = 0;
  localparam int PATH_PRE_BIT = 1;
  localparam int PATH_MUL_BIT = 2;
  localparam int PATH_POST_BIT = 3;
  localparam int RAT_PRE_LSB = 0;
  localparam int RAT_MUL_LSB = 8;
  localparam int RAT_POST_LSB = 16;
  localparam int DET_DLY_LSB = 0;
  localparam int DET_LOW_LSB = 4;
  localparam int DET_HIGH_LSB = 6;
  localparam int DET_LOOP_LSB = 8;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PATH_RST = 32'h0000_0000;
  localparam logic [31:0] RATIO_RST = 32'h0001_0101;
  localparam logic [31:0] NINT_RST = 32'h0000_0064;
  localparam logic [31:0] NUM_RST = 32'h0000_0000;
  localparam logic [31:0] DEN_RST = 32'h0000_0001;
  localparam logic [31:0] DET_RST = 32'h0000_0001;
  localparam logic [7:0] BAND_RST = 8'h80;
endpackage

//--- rtl/mash_modulator.sv
// cascaded accumulator noise shaper, order 0 to 4
// assumes step_in pulses once per feedback divider cycle
`timescale 1ns/1ps
`default_nettype none
module mash_modulator #(
  parameter int W = 32
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic step_in,
  input wire logic seed_in,
  input wire logic [W-1:0] numer_in,
  input wire logic [W-1:0] denom_in,
  input wire logic [W-1:0] seed_val_in,
  input wire logic [2:0] order_in,
  output logic signed [4:0] frac_out
);
  // modular add, carry in the top bit
  function automatic logic [W:0] mod_add(input logic [W-1:0] a,
      input logic [W-1:0] b, input logic [W-1:0] m);
    logic [W:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, m}) begin
      s = s - {1'b0, m};
      return {1'b1, s[W-1:0]};
    end
    return {1'b0, s[W-1:0]};
  endfunction

  logic [W-1:0] acc_reg [4]; // stage residues
  logic signed [4:0] d2_reg, d3_reg, d4_reg; // delayed partial sums
  logic [W-1:0] den; // zero denominator acts as one
  logic [W-1:0] acc_next [4];
  logic [3:0] cy; // stage carries
  logic signed [4:0] t2, t3, t4, y;

  assign den = (denom_in == '0) ? W'(1) : denom_in;

  // stage chain and difference network
  always_comb begin
    logic [W:0] r;
    logic [W-1:0] base;
    r = '0;
    base = seed_in ? W'(mod_add(acc_reg[0], seed_val_in, den))
        : acc_reg[0];
    // first stage integrates the numerator
    r = mod_add(base, numer_in, den);
    cy[0] = r[W] && (order_in != 3'h0);
    acc_next[0] = (order_in != 3'h0) ? r[W-1:0] : '0;
    // later stages integrate the fresh residue of the stage before
    for (int k = 1; k < 4; k++) begin
      r = mod_add(acc_reg[k], acc_next[k - 1], den);
      cy[k] = r[W] && (k < int'(order_in));
      acc_next[k] = (k < int'(order_in)) ? r[W-1:0] : '0;
    end
    t4 = cy[3] ? 5'sh01 : 5'sh00;
    t3 = (cy[2] ? 5'sh01 : 5'sh00) + t4 - d4_reg;
    t2 = (cy[1] ? 5'sh01 : 5'sh00) + t3 - d3_reg;
    y = (cy[0] ? 5'sh01 : 5'sh00) + t2 - d2_reg;
    // integer mode: no offset, and stale differences are flushed
    if (order_in == 3'h0) begin
      t4 = 5'sh00;
      t3 = 5'sh00;
      t2 = 5'sh00;
      y = 5'sh00;
    end
  end

  // advance once per feedback cycle
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      for (int k = 0; k < 4; k++) begin
        acc_reg[k] <= '0;
      end
      d2_reg <= '0;
      d3_reg <= '0;
      d4_reg <= '0;
      frac_out <= '0;
    end else if (step_in) begin
      acc_reg <= acc_next;
      d2_reg <= t2;
      d3_reg <= t3;
      d4_reg <= t4;
      frac_out <= y;
    end else if (seed_in) begin
      acc_reg[0] <= W'(mod_add(acc_reg[0], seed_val_in,
          den));
    end
  end

  a_mash_int_zero: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) step_in && order_in == 3'h0
      |=> frac_out == 5'sh00)
    else $error("integer mode gave a fractional offset");
  a_mash_below_den: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) $rose(step_in) && order_in != 3'h0
      && numer_in < den |=> acc_reg[0] < den)
    else $error("first residue reached the denominator");
endmodule
`default_nettype wire

//--- rtl/fractional_n_divider_chain.sv
// reference path, feedback divider, detector and calibration
// assumes reference and oscillator levels synchronous to clk
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - integer feedback divide is twelve bits
// - noise shaper order one through four
// - denominator any value up to 32 bits
// - average divide is integer plus fraction
// - prescaler divides by two or four
// - doubler fires on both reference edges
// - every reference stage can be bypassed
// - pre-divider divides the doubler output
// - multiplier sits between the two dividers
// - post-divider reaches low detector rates
// - detector compares reference against feedback
// - calibration forces midpoint then picks band
// - seed write shifts the output phase
// - calibrate bit in control starts calibration
module fractional_n_divider_chain (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic reference_input_in,
  input wire logic vco_div_in,
  output logic ref_pd_event_out,
  output logic fb_event_out,
  output logic pfd_up_out,
  output logic pfd_down_out,
  output logic tune_force_mid_out,
  output logic [7:0] vco_band_out,
  output logic cal_busy_out,
  output logic [3:0] detector_delay_setting_out,
  output logic [1:0] low_rate_cal_adjust_out,
  output logic [1:0] high_rate_cal_adjust_out,
  output logic [1:0] detector_loop_select_out
);
  // byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // next count of a divide-by-ratio counter
  function automatic logic [11:0] div_next(input logic [11:0] c,
      input logic [11:0] ratio);
    if (c == 12'h000) begin
      return (ratio == 12'h000) ? 12'h000 : ratio - 12'h001;
    end
    return c - 12'h001;
  endfunction

  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_MID = 3'b010,
    CAL_MEAS = 3'b100
  } cal_state_e;

  // software registers
  logic [31:0] ctrl_reg, path_reg, ratio_reg, nint_reg;
  logic [31:0] num_reg, den_reg, seed_reg, det_reg;
  logic seed_pulse_reg; // phase shift request
  logic ack_reg; // bus answer cycle
  logic wr_ack, rd_ack;
  // reference path
  logic ref_q_reg, vco_q_reg;
  logic ref_edge, ref_rise, dbl_ev, pre_ev, mul_ev, ref_pd;
  logic [11:0] pre_cnt_reg, post_cnt_reg;
  logic [7:0] mul_left_reg;
  // feedback path
  logic [1:0] ps_cnt_reg;
  logic ps_ev, fb_ev;
  logic [12:0] n_cnt_reg;
  logic [12:0] n_load;
  logic signed [4:0] frac;
  logic [2:0] order;
  // detector reset delay
  logic [3:0] pfd_dly_reg;
  // calibration
  cal_state_e cal_state_reg;
  logic [7:0] cal_cnt_reg, fb_cnt_reg, ref_cnt_reg, trial_reg;
  logic cal_start;

  assign order = ctrl_reg[divider_chain_pkg::CTRL_ORD_LSB +: 3];
  assign rd_ack = ack_reg && avs_read_in;
  assign wr_ack = ack_reg && avs_write_in;
  assign cal_start = wr_ack
      && avs_address_in == divider_chain_pkg::REG_CTRL
      && avs_byteenable_in[0]
      && avs_writedata_in[divider_chain_pkg::CTRL_CAL_BIT];

  // answer one cycle after each request
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read_in || avs_write_in) && !ack_reg;
    end
  end
  assign avs_waitrequest_out = !ack_reg;

  // register writes on the answer edge
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ctrl_reg <= divider_chain_pkg::CTRL_RST;
      path_reg <= divider_chain_pkg::PATH_RST;
      ratio_reg <= divider_chain_pkg::RATIO_RST;
      nint_reg <= divider_chain_pkg::NINT_RST;
      num_reg <= divider_chain_pkg::NUM_RST;
      den_reg <= divider_chain_pkg::DEN_RST;
      seed_reg <= divider_chain_pkg::NUM_RST;
      det_reg <= divider_chain_pkg::DET_RST;
      seed_pulse_reg <= 1'b0;
    end else begin
      seed_pulse_reg <= 1'b0;
      if (wr_ack) begin
        unique case (avs_address_in)
          divider_chain_pkg::REG_CTRL: begin
            ctrl_reg <= merge(ctrl_reg, avs_writedata_in,
                avs_byteenable_in) & 32'h0000_001E;
          end
          divider_chain_pkg::REG_PATH: begin
            path_reg <= merge(path_reg, avs_writedata_in,
                avs_byteenable_in) & 32'h0000_000F;
          end
          divider_chain_pkg::REG_RATIO: begin
            ratio_reg <= merge(ratio_reg, avs_writedata_in,
                avs_byteenable_in) & 32'h0FFF_FFFF;
          end
          divider_chain_pkg::REG_NINT: begin
            nint_reg <= merge(nint_reg, avs_writedata_in,
                avs_byteenable_in) & 32'h0000_0FFF;
          end
          divider_chain_pkg::REG_NUM: begin
            num_reg <= merge(num_reg, avs_writedata_in,
                avs_byteenable_in);
          end
          divider_chain_pkg::REG_DEN: begin
            den_reg <= merge(den_reg, avs_writedata_in,
                avs_byteenable_in);
          end
          divider_chain_pkg::REG_SEED: begin
            seed_reg <= merge(seed_reg, avs_writedata_in,
                avs_byteenable_in);
            seed_pulse_reg <= 1'b1;
          end
          divider_chain_pkg::REG_DET: begin
            det_reg <= merge(det_reg, avs_writedata_in,
                avs_byteenable_in) & 32'h0000_03FF;
          end
          default: begin
            // unmapped or read-only: ignored
          end
        endcase
      end
    end
  end

  // read data captured as the answer starts
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      avs_readdata_out <= '0;
    end else if (avs_read_in && !ack_reg) begin
      unique case (avs_address_in)
        divider_chain_pkg::REG_CTRL: avs_readdata_out <= ctrl_reg;
        divider_chain_pkg::REG_PATH: avs_readdata_out <= path_reg;
        divider_chain_pkg::REG_RATIO: avs_readdata_out <= ratio_reg;
        divider_chain_pkg::REG_NINT: avs_readdata_out <= nint_reg;
        divider_chain_pkg::REG_NUM: avs_readdata_out <= num_reg;
        divider_chain_pkg::REG_DEN: avs_readdata_out <= den_reg;
        divider_chain_pkg::REG_SEED: avs_readdata_out <= seed_reg;
        divider_chain_pkg::REG_DET: avs_readdata_out <= det_reg;
        divider_chain_pkg::REG_STAT: begin
          avs_readdata_out <= {20'h00000, pfd_down_out, pfd_up_out,
              vco_band_out, 1'b0, cal_busy_out};
        end
        default: avs_readdata_out <= '0;
      endcase
    end
  end

  // detector settings driven straight to the analog side
  assign detector_delay_setting_out =
      det_reg[divider_chain_pkg::DET_DLY_LSB +: 4];
  assign low_rate_cal_adjust_out =
      det_reg[divider_chain_pkg::DET_LOW_LSB +: 2];
  assign high_rate_cal_adjust_out =
      det_reg[divider_chain_pkg::DET_HIGH_LSB +: 2];
  assign detector_loop_select_out =
      det_reg[divider_chain_pkg::DET_LOOP_LSB +: 2];

  // input level history for edge detection
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ref_q_reg <= 1'b0;
      vco_q_reg <= 1'b0;
    end else begin
      ref_q_reg <= reference_input_in;
      vco_q_reg <= vco_div_in;
    end
  end
  assign ref_edge = reference_input_in ^ ref_q_reg;
  assign ref_rise = reference_input_in && !ref_q_reg;

  // doubler: one event per edge when engaged
  assign dbl_ev = path_reg[divider_chain_pkg::PATH_DBL_BIT]
      ? ref_edge : ref_rise;
  // pre-divider output event
  assign pre_ev = path_reg[divider_chain_pkg::PATH_PRE_BIT]
      ? (dbl_ev && pre_cnt_reg == 12'h000) : dbl_ev;
  // multiplier emits a burst while events remain
  assign mul_ev = path_reg[divider_chain_pkg::PATH_MUL_BIT]
      ? (mul_left_reg != 8'h00) : pre_ev;
  // post-divider output feeds the detector
  assign ref_pd = path_reg[divider_chain_pkg::PATH_POST_BIT]
      ? (mul_ev && post_cnt_reg == 12'h000) : mul_ev;

  // pre-divider counter
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pre_cnt_reg <= '0;
    end else if (dbl_ev) begin
      pre_cnt_reg <= div_next(pre_cnt_reg,
          {4'h0, ratio_reg[divider_chain_pkg::RAT_PRE_LSB +: 8]});
    end
  end

  // multiplier burst counter, reloaded per input event
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      mul_left_reg <= '0;
    end else if (pre_ev) begin
      mul_left_reg <= ratio_reg[divider_chain_pkg::RAT_MUL_LSB +: 8];
    end else if (mul_left_reg != 8'h00) begin
      mul_left_reg <= mul_left_reg - 8'h01;
    end
  end

  // post-divider counter
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      post_cnt_reg <= '0;
    end else if (mul_ev) begin
      post_cnt_reg <= div_next(post_cnt_reg,
          ratio_reg[divider_chain_pkg::RAT_POST_LSB +: 12]);
    end
  end

  // prescaler by two or four on oscillator edges
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ps_cnt_reg <= '0;
    end else if (vco_div_in && !vco_q_reg) begin
      if (ps_cnt_reg == 2'h0) begin
        ps_cnt_reg <= ctrl_reg[divider_chain_pkg::CTRL_PRE4_BIT]
            ? 2'h3 : 2'h1;
      end else begin
        ps_cnt_reg <= ps_cnt_reg - 2'h1;
      end
    end
  end
  assign ps_ev = vco_div_in && !vco_q_reg && ps_cnt_reg == 2'h0;

  // next divide: integer value plus modulator offset
  always_comb begin
    logic [12:0] s;
    s = {1'b0, nint_reg[11:0]} + 13'({{8{frac[4]}}, frac});
    n_load = (s == 13'h0000 || s[12]) ? 13'h0001 : s;
  end

  // feedback counter, one output per loaded count
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      n_cnt_reg <= '0;
    end else if (ps_ev) begin
      n_cnt_reg <= (n_cnt_reg == 13'h0000)
          ? n_load - 13'h0001 : n_cnt_reg - 13'h0001;
    end
  end
  assign fb_ev = ps_ev && n_cnt_reg == 13'h0000;

  // modulator advanced once per feedback output
  mash_modulator #(
    .W(32)
  ) u_mash (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .step_in(fb_ev),
    .seed_in(seed_pulse_reg),
    .numer_in(num_reg),
    .denom_in(den_reg),
    .seed_val_in(seed_reg),
    .order_in(order),
    .frac_out(frac)
  );

  // event pulses from flops
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ref_pd_event_out <= 1'b0;
      fb_event_out <= 1'b0;
    end else begin
      ref_pd_event_out <= ref_pd;
      fb_event_out <= fb_ev;
    end
  end

  // phase detector: set wins over the delayed reset
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pfd_up_out <= 1'b0;
      pfd_down_out <= 1'b0;
      pfd_dly_reg <= '0;
    end else begin
      if (pfd_up_out && pfd_down_out) begin
        pfd_dly_reg <= pfd_dly_reg + 4'h1;
        if (pfd_dly_reg >= detector_delay_setting_out) begin
          pfd_up_out <= ref_pd;
          pfd_down_out <= fb_ev;
          pfd_dly_reg <= '0;
        end
      end else begin
        pfd_up_out <= pfd_up_out || ref_pd;
        pfd_down_out <= pfd_down_out || fb_ev;
      end
    end
  end

  // calibration: hold midpoint, then binary band search
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cal_state_reg <= CAL_IDLE;
      cal_cnt_reg <= '0;
      fb_cnt_reg <= '0;
      ref_cnt_reg <= '0;
      trial_reg <= '0;
      vco_band_out <= divider_chain_pkg::BAND_RST;
    end else if (cal_start) begin
      cal_state_reg <= CAL_MID;
      cal_cnt_reg <= 8'(divider_chain_pkg::CAL_MID_CYC);
      vco_band_out <= divider_chain_pkg::BAND_RST;
      trial_reg <= divider_chain_pkg::BAND_RST;
    end else begin
      unique case (cal_state_reg)
        CAL_IDLE: begin
          cal_cnt_reg <= '0;
        end
        CAL_MID: begin
          cal_cnt_reg <= cal_cnt_reg - 8'h01;
          if (cal_cnt_reg == 8'h01) begin
            cal_state_reg <= CAL_MEAS;
            fb_cnt_reg <= '0;
            ref_cnt_reg <= '0;
          end
        end
        CAL_MEAS: begin
          if (fb_ev && fb_cnt_reg != 8'hFF) begin
            fb_cnt_reg <= fb_cnt_reg + 8'h01;
          end
          if (ref_pd) begin
            ref_cnt_reg <= ref_cnt_reg + 8'h01;
          end
          if (ref_pd && ref_cnt_reg ==
              8'(divider_chain_pkg::CAL_WIN - 1)) begin
            // too fast: drop the trial bit
            if (fb_cnt_reg > 8'(divider_chain_pkg::CAL_WIN)) begin
              vco_band_out <= (vco_band_out & ~trial_reg)
                  | (trial_reg >> 1);
            end else begin
              vco_band_out <= vco_band_out | (trial_reg >> 1);
            end
            trial_reg <= trial_reg >> 1;
            fb_cnt_reg <= '0;
            ref_cnt_reg <= '0;
            if (trial_reg == 8'h01) begin
              cal_state_reg <= CAL_IDLE;
            end
          end
        end
      endcase
    end
  end
  assign tune_force_mid_out = cal_state_reg == CAL_MID;
  assign cal_busy_out = cal_state_reg != CAL_IDLE;

  a_bus_answer: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) (avs_read_in || avs_write_in)
      && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer not one cycle after request");
  a_cal_start: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) cal_start
      |=> tune_force_mid_out [*8])
    else $error("calibration did not start at midpoint");
  a_cal_order: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) $fell(tune_force_mid_out)
      && !cal_start |-> cal_state_reg == CAL_MEAS)
    else $error("band search did not follow midpoint");
  a_dbl_edge: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      path_reg[divider_chain_pkg::PATH_DBL_BIT] && $fell(
      reference_input_in) |-> dbl_ev)
    else $error("doubler missed a falling edge");
  a_pre_bypass: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      !path_reg[divider_chain_pkg::PATH_PRE_BIT]
      |-> pre_ev == dbl_ev)
    else $error("bypassed pre-divider altered events");
  a_fb_reload: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) fb_ev
      |=> n_cnt_reg == $past(n_load) - 13'h0001)
    else $error("feedback counter reload wrong");
  a_pfd_up_set: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) ref_pd |=> pfd_up_out)
    else $error("reference event did not raise up");
  a_presc_half: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) ps_ev
      && !ctrl_reg[divider_chain_pkg::CTRL_PRE4_BIT]
      |=> ps_cnt_reg == 2'h1)
    else $error("prescaler by two reloaded wrong");
endmodule
`default_nettype wire

//--- testbench/fractional_n_divider_chain_tb.sv
// self-checking bench for the fractional-n divider chain
// assumes one avalon wait state and registered event outputs
`timescale 1ns/1ps
`default_nettype none
module fractional_n_divider_chain_tb;
  // bench-driven inputs
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [5:0] addr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] be = 4'hF;
  logic ref_in = 1'b0;
  logic vco_in = 1'b0;
  // observed outputs
  logic [31:0] rdata;
  logic waitreq, ref_ev, fb_ev, up, down, mid, busy;
  logic [7:0] band;
  logic [3:0] dly;
  logic [1:0] lowa, higha, loops;
  // score keeping
  int err_count = 0;
  int checked = 0;
  int n_ref, n_fb, n_up, n_dn;
  logic [31:0] q;

  fractional_n_divider_chain u_fractional_n_divider_chain (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .reference_input_in(ref_in), .vco_div_in(vco_in),
    .ref_pd_event_out(ref_ev), .fb_event_out(fb_ev),
    .pfd_up_out(up), .pfd_down_out(down), .tune_force_mid_out(mid),
    .vco_band_out(band), .cal_busy_out(busy),
    .detector_delay_setting_out(dly), .low_rate_cal_adjust_out(lowa),
    .high_rate_cal_adjust_out(higha), .detector_loop_select_out(loops)
  );

  // 100 MHz clock
  always #5 clk_sys_in = ~clk_sys_in;

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    be <= b;
    wr <= w;
    rd <= ~w;
    // waitrequest and read data seen as sampled at each rising edge
    do begin
      @(posedge clk_sys_in);
    end while (waitreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    check(q, exp);
  endtask

  // run traffic: reference toggles every rp cycles, oscillator every cycle
  task automatic run(input int cyc, input int rp, input logic osc);
    n_ref = 0;
    n_fb = 0;
    n_up = 0;
    n_dn = 0;
    for (int i = 0; i < cyc; i++) begin
      @(posedge clk_sys_in);
      n_ref += int'(ref_ev);
      n_fb += int'(fb_ev);
      n_up += int'(up);
      n_dn += int'(down);
      ref_in <= 1'((i / rp) % 2);
      vco_in <= osc & ~vco_in;
    end
  endtask

  // count within a tolerance
  task automatic near(input int seen, input int exp, input int tol);
    check(32'(seen >= exp - tol && seen <= exp + tol), 32'h1);
  endtask

  // reset values and register widths
  task automatic t_regs();
    rchk(divider_chain_pkg::REG_NINT, divider_chain_pkg::NINT_RST);
    rchk(divider_chain_pkg::REG_RATIO, 32'h0001_0101);
    check(32'(band), 32'h80);
    check(32'(dly), 32'h1);
    wreg(divider_chain_pkg::REG_NINT, 32'hFFFF_FFFF);
    rchk(divider_chain_pkg::REG_NINT, 32'h0000_0FFF);
    wreg(divider_chain_pkg::REG_DEN, 32'hFFFF_FFFF);
    rchk(divider_chain_pkg::REG_DEN, 32'hFFFF_FFFF);
    wreg(divider_chain_pkg::REG_NUM, 32'h0000_0000);
    bus(1'b1, divider_chain_pkg::REG_NUM, 32'hAABB_CCDD, 4'h1);
    rchk(divider_chain_pkg::REG_NUM, 32'h0000_00DD);
    rchk(6'h24, 32'h0000_0000);
    wreg(divider_chain_pkg::REG_DET, 32'h0000_03F8);
    @(posedge clk_sys_in);
    check(32'({dly, lowa, higha, loops}), 32'h0000_023F);
    $display("test regs done");
  endtask

  // each reference stage alone, 20 rising edges in
  task automatic t_ref();
    logic [3:0] pth [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
    logic [31:0] rat [5] = '{32'h0001_0101, 32'h0001_0101, 32'h0001_0104,
                            32'h0001_0301, 32'h0002_0101};
    int exp [5] = '{20, 40, 5, 60, 10};
    for (int k = 0; k < 5; k++) begin
      wreg(divider_chain_pkg::REG_RATIO, rat[k]);
      wreg(divider_chain_pkg::REG_PATH, {28'h0, pth[k]});
      run(160, 4, 1'b0);
      near(n_ref, exp[k], 2);
      if (k == 0) check(32'(n_up > 0), 32'h1);
    end
    wreg(divider_chain_pkg::REG_RATIO, 32'h0001_0101);
    wreg(divider_chain_pkg::REG_PATH, 32'h0000_0000);
    $display("test ref done");
  endtask

  // average divide 30.5 for each order, 30 when integer
  task automatic t_frac();
    wreg(divider_chain_pkg::REG_NINT, 32'd30);
    wreg(divider_chain_pkg::REG_NUM, 32'd1);
    wreg(divider_chain_pkg::REG_DEN, 32'd2);
    for (int o = 0; o < 5; o++) begin
      wreg(divider_chain_pkg::REG_DET,
           (o < 2) ? 32'h1 : (o < 4) ? 32'h2 : 32'h8);
      wreg(divider_chain_pkg::REG_CTRL, 32'(o << 1));
      run(14640, 4, 1'b1);
      near(n_fb, (o == 0) ? 122 : 120, 1);
    end
    check(32'(n_dn > 0), 32'h1);
    wreg(divider_chain_pkg::REG_CTRL, 32'h0000_0010);
    run(7320, 4, 1'b1);
    near(n_fb, 30, 1);
    $display("test frac done");
  endtask

  // calibration: midpoint hold, then band search to completion
  task automatic t_cal();
    int n;
    n = 0;
    wreg(divider_chain_pkg::REG_CTRL, 32'h0000_0001);
    @(negedge clk_sys_in);
    check(32'(busy), 32'h1);
    while (mid === 1'b1 && n < 300) begin
      n++;
      @(negedge clk_sys_in);
    end
    check(32'(n), 32'(divider_chain_pkg::CAL_MID_CYC));
    check(32'(busy), 32'h1);
    run(1400, 4, 1'b1);
    check(32'(busy), 32'h0);
    check(32'(band), 32'hFF);
    $display("test cal done");
  endtask

  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog over the whole sequence
  initial begin
    #950_000;
    err_count++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    stop_test();
  end

  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    t_regs();
    t_ref();
    t_frac();
    t_cal();
    stop_test();
  end
endmodule
`default_nettype wire
